// [bench/flash_backdoor_key_and_margin_cmd_tb.sv]
// Self-checking bench for the flash command sequencer
`timescale 1ns/1ps
`default_nettype none
`include "flash_cmd_regs.vh"
module flash_backdoor_key_and_margin_cmd_tb;
  logic pclk, presetn, clk_en, psel, penable, pwrite, slv;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, secured, margin_valid, irq, err_m, lock_m, unsec_m, ok_m;
  logic [63:0] stored_key;
  logic [6:0] flash_clock_divider, margin_block, blk;
  logic [15:0] margin_level;
  logic [15:0] key [4];
  logic [31:0] seed = 32'h0000_0021;
  int fail_count = 0;
  int compares = 0;
  flash_backdoor_key_and_margin_cmd uut (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .stored_key(stored_key), .secured(secured),
    .flash_clock_divider(flash_clock_divider), .margin_block(margin_block),
    .margin_level(margin_level), .margin_valid(margin_valid), .irq(irq));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic report_and_stop();
    if (fail_count == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Loads the object words, launches, then polls until complete
  task automatic run(logic [15:0] w0, logic [2:0] last, int n);
    apb(1'b1, `OFS_INDEX, 32'h0);
    apb(1'b1, `OFS_OBJECT, {16'h0, w0});
    for (int i = 1; i <= n; i++)
    begin
      apb(1'b1, `OFS_INDEX, i);
      apb(1'b1, `OFS_OBJECT, {16'h0, key[i-1]});
    end
    apb(1'b1, `OFS_INDEX, {29'h0, last});
    apb(1'b1, `OFS_STATUS, 32'h0000_0080);
    rd = 32'h0;
    for (int t = 0; t < 20 && rd[`ST_COMMAND_COMPLETE_FLAG] !== 1'b1; t++)
      apb(1'b0, `OFS_STATUS, 32'h0);
  endtask
  task automatic clear_err();
    apb(1'b1, `OFS_STATUS, 32'h0000_0020);
    err_m = 1'b0;
  endtask
  // Wrong key differs only in the last word, the latest point to catch it
  task automatic verify(logic [1:0] en, logic [2:0] last, logic good);
    apb(1'b1, `OFS_SECCFG, {24'h0, en, 6'h00});
    for (int i = 0; i < 4; i++)
      key[i] = stored_key[63-16*i -: 16] ^ {15'h0, !good && i == 3};
    run(16'h0C00, last, 4);
    ok_m = en == 2'h2 && last == 3'h4 && !lock_m;
    lock_m = lock_m | (ok_m && !good);
    unsec_m = unsec_m | (ok_m && good);
    err_m = err_m | !(ok_m && good);
    check("status", {24'h0, 2'h2, err_m, 5'h00}, rd);
    apb(1'b0, `OFS_SECCFG, 32'h0);
    check("seccfg", {24'h0, en, 5'h00, unsec_m}, rd);
    check("secured", {31'h0, !unsec_m}, {31'h0, secured});
  endtask
  task automatic do_reset();
    presetn <= 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    {err_m, lock_m, unsec_m} = 3'h0;
  endtask
  // ----------------------------------------
  // Clock, watchdog, sequence
  // ----------------------------------------
  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  initial
  begin
    #800000;
    fail_count++;
    report_and_stop();
  end
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    clk_en = 1'b1;
    presetn = 1'b0;
    stored_key = {rnd(), rnd()};
    do_reset();
    apb(1'b0, `OFS_STATUS, 32'h0);
    check("status", 32'h0000_0080, rd);
    apb(1'b1, `OFS_IRQ_MASK, 32'h0000_0003);
    for (int e = 0; e < 4; e++)
      if (e != 2)
        verify(e[1:0], 3'h4, 1'b1);
    check("irq", 32'h1, {31'h0, irq});
    apb(1'b1, `OFS_IRQ_STAT, 32'h0000_0003);
    // Clear lands at the access edge; look once it has settled
    @(posedge pclk);
    check("irq", 32'h0, {31'h0, irq});
    clear_err();
    verify(2'h2, 3'h3, 1'b1);
    clear_err();
    verify(2'h2, 3'h4, 1'b0);
    clear_err();
    verify(2'h2, 3'h4, 1'b1);
    do_reset();
    apb(1'b1, `OFS_IRQ_MASK, 32'h0);
    verify(2'h2, 3'h4, 1'b1);
    check("irq", 32'h0, {31'h0, irq});
    for (int m = 0; m < 3; m++)
    begin
      blk = 7'(rnd());
      key[0] = 16'(rnd());
      run({8'h0D, 1'b0, blk}, 3'h1, 1);
      check("status", 32'h0000_0080, rd);
      check("margin", {9'h0, blk, key[0]}, {9'h0, margin_block, margin_level});
      apb(1'b0, `OFS_MARGIN, 32'h0);
      check("margin reg", {9'h100, blk, key[0]}, rd);
    end
    // Margin at the wrong index and an unknown code are both refused
    run({8'h0D, 1'b0, ~blk}, 3'h0, 1);
    check("status", 32'h0000_00A0, rd);
    check("margin", {9'h0, blk, key[0]}, {9'h0, margin_block, margin_level});
    clear_err();
    run(16'h0E00, 3'h0, 0);
    check("status", 32'h0000_00A0, rd);
    clk_en <= 1'b0;
    apb(1'b1, `OFS_CLKDIV, 32'h0000_0005);
    clk_en <= 1'b1;
    @(posedge pclk);
    check("divider", 32'h0, {25'h0, flash_clock_divider});
    apb(1'b1, `OFS_CLKDIV, 32'h0000_002F);
    apb(1'b1, `OFS_CLKDIV, 32'h0000_0001);
    @(posedge pclk);
    check("divider", 32'h2F, {25'h0, flash_clock_divider});
    apb(1'b0, 12'h020, 32'h0);
    check("slverr", 32'h1, {31'h0, slv});
    check("unmapped", 32'h0, rd);
    report_and_stop();
  end
endmodule // flash_backdoor_key_and_margin_cmd_tb
`default_nettype wire

// [bench/flash_cmd_monitor.sv]
// Port-level assertions for the flash command sequencer
`timescale 1ns/1ps
`default_nettype none
`include "flash_cmd_regs.vh"
module flash_cmd_monitor #(
  parameter LEVEL_W = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  input wire logic secured,
  input wire logic [6:0] flash_clock_divider,
  input wire logic [LEVEL_W-1:0] margin_level,
  input wire logic margin_valid
);
  // ----------------------------------------
  // Helper logic
  // ----------------------------------------
  logic [3:0] since_r;
  logic div_done_r;
  wire wr_acc = psel && penable && pwrite && clk_en;
  wire launch = wr_acc && paddr == `OFS_STATUS && pwdata[`ST_COMMAND_COMPLETE_FLAG];
  // Saturates so an idle run never wraps into a false window
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      since_r <= 4'hF;
      div_done_r <= 1'b0;
    end
    else if (clk_en)
    begin
      since_r <= launch ? 4'h0 : (since_r == 4'hF ? since_r : since_r + 4'h1);
      div_done_r <= div_done_r | (wr_acc && paddr == `OFS_CLKDIV);
    end
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_ready_high: assert property (pready) else $error("pready low");
  // Unaligned offsets are unmapped too, not only those past the last register
  chk_slverr_map: assert property (pslverr == (psel && penable
    && (paddr > `OFS_IRQ_MASK || paddr[1:0] != 2'h0))) else $error("pslverr wrong");
  chk_secure_sticky: assert property (!secured |=> !secured) else $error("secured came back");
  chk_unlock_time: assert property ($fell(secured) |-> since_r >= 4 && since_r <= 6)
    else $error("unlock timing");
  chk_margin_time: assert property ($changed(margin_level) |-> since_r <= 3)
    else $error("margin changed late");
  chk_margin_hold: assert property (margin_valid |=> margin_valid) else $error("margin lost");
  chk_div_once: assert property ($changed(flash_clock_divider) |->
    $past(wr_acc && paddr == `OFS_CLKDIV && !div_done_r)) else $error("divider changed");
  chk_prdata_load: assert property ($changed(prdata) |-> $past(psel && !penable && !pwrite))
    else $error("prdata moved");
endmodule // flash_cmd_monitor
bind flash_backdoor_key_and_margin_cmd flash_cmd_monitor #(.LEVEL_W(LEVEL_W)) mon (
  .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .prdata(prdata), .secured(secured), .flash_clock_divider(flash_clock_divider),
  .margin_level(margin_level), .margin_valid(margin_valid));
`default_nettype wire

// [src/flash_backdoor_key_and_margin_cmd.v]
// Flash command sequencer: backdoor key verify, user margin level, clock divider
`timescale 1ns/1ps
`default_nettype none
`include "flash_cmd_regs.vh"

module flash_backdoor_key_and_margin_cmd #(
  parameter WORD_W = 16,
  parameter NUM_WORDS = 5,
  parameter BLOCK_W = 7,
  parameter LEVEL_W = 16
) (
  input wire pclk,
  input wire presetn,
  input wire clk_en,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output wire pslverr,
  output reg [31:0] prdata,
  input wire [63:0] stored_key,
  output wire secured,
  output wire [6:0] flash_clock_divider,
  output wire [BLOCK_W-1:0] margin_block,
  output wire [LEVEL_W-1:0] margin_level,
  output wire margin_valid,
  output wire irq
);

  // ----------------------------------------
  // State machine codes
  // ----------------------------------------
  localparam S_IDLE = 2'b00;
  localparam S_CHECK = 2'b01;
  localparam S_CMP = 2'b10;
  localparam S_DONE = 2'b11;

  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg [WORD_W-1:0] command_object_regs [0:NUM_WORDS-1];
  reg [2:0] command_object_index;
  reg [2:0] launch_index_r;
  reg command_complete_flag;
  reg access_error_flag;
  reg [7:0] security_config_reg;
  reg key_locked_r;
  reg [6:0] div_r;
  reg div_set_r;
  reg [BLOCK_W-1:0] mblock_r;
  reg [LEVEL_W-1:0] mlevel_r;
  reg mvalid_r;
  reg [2:0] cmp_idx_r;
  reg mismatch_r;
  reg [1:0] irq_stat_r;
  reg [1:0] irq_mask_r;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  function is_mapped;
    input [11:0] a;
    begin
      if (a == `OFS_STATUS) is_mapped = 1'b1;
      else if (a == `OFS_INDEX) is_mapped = 1'b1;
      else if (a == `OFS_OBJECT) is_mapped = 1'b1;
      else if (a == `OFS_SECCFG) is_mapped = 1'b1;
      else if (a == `OFS_CLKDIV) is_mapped = 1'b1;
      else if (a == `OFS_MARGIN) is_mapped = 1'b1;
      else if (a == `OFS_IRQ_STAT) is_mapped = 1'b1;
      else if (a == `OFS_IRQ_MASK) is_mapped = 1'b1;
      else is_mapped = 1'b0;
    end
  endfunction

  wire access = psel & penable & clk_en;
  wire wr = access & pwrite & is_mapped(paddr);
  wire wr_status = wr & (paddr == `OFS_STATUS);
  wire wr_index = wr & (paddr == `OFS_INDEX);
  wire wr_object = wr & (paddr == `OFS_OBJECT) & (state_r == S_IDLE);
  wire wr_seccfg = wr & (paddr == `OFS_SECCFG);
  wire wr_clkdiv = wr & (paddr == `OFS_CLKDIV);
  wire wr_irq_stat = wr & (paddr == `OFS_IRQ_STAT);
  wire wr_irq_mask = wr & (paddr == `OFS_IRQ_MASK);

  // Zero wait states; slave error on unmapped offsets
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~is_mapped(paddr);

  // Writing one to the complete flag while idle starts the loaded command
  wire launch = wr_status & pwdata[`ST_COMMAND_COMPLETE_FLAG] & command_complete_flag;

  // ----------------------------------------
  // Command decode
  // ----------------------------------------
  wire [7:0] cmd_code = command_object_regs[`IDX_CODE][WORD_W-1:WORD_W-8];
  wire is_verify = (cmd_code == `CMD_VERIFY_KEY);
  wire is_margin = (cmd_code == `CMD_SET_MARGIN);
  wire keys_enabled = (security_config_reg[`SEC_BACKDOOR_KEY_ENABLE_HI:`SEC_BACKDOOR_KEY_ENABLE_LO] == `BACKDOOR_KEY_ENABLE_ENABLED);

  // Word of the stored key that lines up with the word under comparison
  reg [WORD_W-1:0] key_word;
  always @*
  begin
    key_word = {WORD_W{1'b0}};
    case (cmp_idx_r)
      3'h1: key_word = stored_key[63:48];
      3'h2: key_word = stored_key[47:32];
      3'h3: key_word = stored_key[31:16];
      3'h4: key_word = stored_key[15:0];
      default: key_word = {WORD_W{1'b0}};
    endcase
  end

  // Error verdict taken in the check state, before any comparison
  wire verify_reject = ~keys_enabled | key_locked_r | (launch_index_r != `IDX_KEY_LAST);
  wire cmp_fail = mismatch_r | (command_object_regs[cmp_idx_r] != key_word);
  wire last_cmp = (cmp_idx_r == `IDX_KEY_LAST);

  always @*
  begin
    state_nxt = state_r;
    case (state_r)
      S_IDLE:
        if (launch)
          state_nxt = S_CHECK;
      S_CHECK:
        if (is_verify & ~verify_reject)
          state_nxt = S_CMP;
        else
          state_nxt = S_DONE;
      S_CMP:
        if (last_cmp)
          state_nxt = S_DONE;
      default:
        state_nxt = S_IDLE;
    endcase
  end

  // Hardware error event for this cycle; it wins over a software clear
  wire err_check = (state_r == S_CHECK) & ~(is_margin & launch_index_r == `IDX_ARG1)
    & ~(is_verify & ~verify_reject);
  wire err_cmp = (state_r == S_CMP) & last_cmp & cmp_fail;
  wire err_event = err_check | err_cmp;
  wire done_event = (state_r == S_DONE);

  // ----------------------------------------
  // Sequencer and flags
  // ----------------------------------------
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_r <= S_IDLE;
      launch_index_r <= 3'h0;
      command_complete_flag <= 1'b1;
      access_error_flag <= 1'b0;
      key_locked_r <= 1'b0;
      security_config_reg <= `SECCFG_RESET;
      cmp_idx_r <= 3'h0;
      mismatch_r <= 1'b0;
      mblock_r <= {BLOCK_W{1'b0}};
      mlevel_r <= {LEVEL_W{1'b0}};
      mvalid_r <= 1'b0;
    end
    else if (clk_en)
    begin
      state_r <= state_nxt;
      if (launch)
      begin
        launch_index_r <= command_object_index;
        command_complete_flag <= 1'b0;
      end
      else if (done_event)
        command_complete_flag <= 1'b1;
      if (err_event)
        access_error_flag <= 1'b1;
      else if (wr_status & pwdata[`ST_ACCESS_ERROR_FLAG])
        access_error_flag <= 1'b0;
      if (state_r == S_CHECK)
      begin
        cmp_idx_r <= `IDX_ARG1;
        mismatch_r <= 1'b0;
      end
      else if (state_r == S_CMP)
      begin
        cmp_idx_r <= cmp_idx_r + 3'h1;
        mismatch_r <= cmp_fail;
      end
      // Mismatch locks out key verify until the next reset
      if (err_cmp)
        key_locked_r <= 1'b1;
      if ((state_r == S_CMP) & last_cmp & ~cmp_fail)
        security_config_reg[`SEC_UNSEC] <= 1'b1;
      // Separate bits, so a write in the unlock cycle is not lost
      if (wr_seccfg)
        security_config_reg[7:1] <= pwdata[7:1];
      if ((state_r == S_CHECK) & is_margin & (launch_index_r == `IDX_ARG1))
      begin
        mblock_r <= command_object_regs[`IDX_CODE][BLOCK_W-1:0];
        mlevel_r <= command_object_regs[`IDX_ARG1][LEVEL_W-1:0];
        mvalid_r <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Command object storage and index
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NUM_WORDS; gi = gi + 1)
    begin : g_obj
      always @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          command_object_regs[gi] <= {WORD_W{1'b0}};
        else if (clk_en & wr_object & (command_object_index == gi))
          command_object_regs[gi] <= pwdata[WORD_W-1:0];
      end
    end
  endgenerate

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      command_object_index <= 3'h0;
      div_r <= `DIV_RESET;
      div_set_r <= 1'b0;
      irq_stat_r <= 2'b00;
      irq_mask_r <= 2'b00;
    end
    else if (clk_en)
    begin
      if (wr_index)
        command_object_index <= pwdata[2:0];
      // Divider takes one write after reset; later writes are ignored
      if (wr_clkdiv & ~div_set_r)
      begin
        div_r <= pwdata[6:0];
        div_set_r <= 1'b1;
      end
      irq_stat_r[`IRQ_DONE] <= done_event | (irq_stat_r[`IRQ_DONE]
        & ~(wr_irq_stat & pwdata[`IRQ_DONE]));
      irq_stat_r[`IRQ_ERR] <= err_event | (irq_stat_r[`IRQ_ERR]
        & ~(wr_irq_stat & pwdata[`IRQ_ERR]));
      if (wr_irq_mask)
        irq_mask_r <= pwdata[1:0];
    end
  end

  // ----------------------------------------
  // Read data, captured in the setup cycle
  // ----------------------------------------
  reg [31:0] rd_nxt;
  always @*
  begin
    rd_nxt = 32'h0000_0000;
    if (paddr == `OFS_STATUS)
    begin
      rd_nxt[`ST_COMMAND_COMPLETE_FLAG] = command_complete_flag;
      rd_nxt[`ST_ACCESS_ERROR_FLAG] = access_error_flag;
    end
    else if (paddr == `OFS_INDEX)
      rd_nxt[2:0] = command_object_index;
    else if (paddr == `OFS_OBJECT)
    begin
      if (command_object_index < NUM_WORDS)
        rd_nxt[WORD_W-1:0] = command_object_regs[command_object_index];
    end
    else if (paddr == `OFS_SECCFG)
      rd_nxt[7:0] = security_config_reg;
    else if (paddr == `OFS_CLKDIV)
      rd_nxt[7:0] = {div_set_r, div_r};
    else if (paddr == `OFS_MARGIN)
      rd_nxt[31:0] = {mvalid_r, {(15-BLOCK_W){1'b0}}, mblock_r, mlevel_r};
    else if (paddr == `OFS_IRQ_STAT)
      rd_nxt[1:0] = irq_stat_r;
    else if (paddr == `OFS_IRQ_MASK)
      rd_nxt[1:0] = irq_mask_r;
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (clk_en & psel & ~penable & ~pwrite)
      prdata <= rd_nxt;
  end

  assign secured = ~security_config_reg[`SEC_UNSEC];
  assign flash_clock_divider = div_r;
  assign margin_block = mblock_r;
  assign margin_level = mlevel_r;
  assign margin_valid = mvalid_r;
  assign irq = |(irq_stat_r & irq_mask_r);

endmodule // flash_backdoor_key_and_margin_cmd
`default_nettype wire

// [src/flash_cmd_regs.vh]
// Register map, field positions and codes for the flash command sequencer
`ifndef FLASH_CMD_REGS_VH
`define FLASH_CMD_REGS_VH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFS_STATUS 12'h000
`define OFS_INDEX 12'h004
`define OFS_OBJECT 12'h008
`define OFS_SECCFG 12'h00C
`define OFS_CLKDIV 12'h010
`define OFS_MARGIN 12'h014
`define OFS_IRQ_STAT 12'h018
`define OFS_IRQ_MASK 12'h01C
// ----------------------------------------
// Status fields
// ----------------------------------------
`define ST_COMMAND_COMPLETE_FLAG 7
`define ST_ACCESS_ERROR_FLAG 5
`define ST_PROTECTION_VIOLATION_FLAG 4
`define ST_MG_HI 1
`define ST_MG_LO 0
// ----------------------------------------
// Security configuration fields and reset
// ----------------------------------------
`define SEC_BACKDOOR_KEY_ENABLE_HI 7
`define SEC_BACKDOOR_KEY_ENABLE_LO 6
`define SEC_UNSEC 0
`define BACKDOOR_KEY_ENABLE_ENABLED 2'h2
`define SECCFG_RESET 8'h00
// ----------------------------------------
// Command object layout and codes
// ----------------------------------------
`define IDX_CODE 3'h0
`define IDX_ARG1 3'h1
`define IDX_KEY_LAST 3'h4
`define CMD_VERIFY_KEY 8'h0C
`define CMD_SET_MARGIN 8'h0D
// ----------------------------------------
// Clock divider and interrupt fields
// ----------------------------------------
`define DIV_SET_BIT 7
`define DIV_RESET 7'h00
`define IRQ_DONE 0
`define IRQ_ERR 1
`endif
